// *** pkg/ipb_map.vh ***
// register map of the interrupt priority bank: offsets, field positions, reset values
// assumes a 32-bit axi4-lite slave with one aligned word per register
`ifndef IPB_MAP_VH
`define IPB_MAP_VH

// ===========================================================================
// register offsets (byte addresses)
`define IPB_OFF_PRIO0 8'h00
`define IPB_OFF_PRIO1 8'h04
`define IPB_OFF_PRIO2 8'h08
`define IPB_OFF_PRIO3 8'h0c
`define IPB_OFF_ENABLE 8'h10
`define IPB_OFF_PENDING 8'h14
`define IPB_OFF_REQUEST 8'h18

// ===========================================================================
// field layout inside each priority register
`define IPB_FLD_W 3
`define IPB_FLD0_LSB 0
`define IPB_FLD1_LSB 4
`define IPB_FLD2_LSB 8
`define IPB_FLD3_LSB 12
`define IPB_PRIO_IMPL_MASK 16'h7777

// ===========================================================================
// reset values
`define IPB_PRIO_RESET 16'h4444
`define IPB_ENABLE_RESET 16'h0000

// ===========================================================================
// level codes
`define IPB_LEVEL_OFF 3'h0
`define IPB_LEVEL_MIN 3'h1
`define IPB_LEVEL_MAX 3'h7

// ===========================================================================
// bus answers
`define IPB_RESP_OKAY 2'h0
`define IPB_RESP_SLVERR 2'h2

`endif

// *** hdl/ipb_source_gate.v ***
// per-source gate: turns a level field plus flag and enable into a forwarded level
// assumes flag and enable are synchronous to aclk
`include "ipb_map.vh"

module ipb_source_gate (
  input wire [2:0] level,
  input wire flag,
  input wire enable,
  output wire requesting,
  output wire [2:0] eff_level
);

  // ===========================================================================
  // gating
  // code 000 disables, 001..111 are levels 1..7 taken unchanged
  assign requesting = flag & enable & (level != `IPB_LEVEL_OFF);
  assign eff_level = requesting ? level : `IPB_LEVEL_OFF;

endmodule // ipb_source_gate

// *** hdl/ipb_priority_bank.v ***
// bank of four 16-bit priority registers for sixteen sources, with axi4-lite access
// assumes source flags come from logic on aclk; the arbiter reads the level outputs
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`include "ipb_map.vh"

// Summary of operation
// - code 111 means level 7, highest
// - code 001 means level 1, lowest active
// - code 000 disables the source entirely
// - bits 15,11,7,3 read zero, ignore writes
// - every field resets to 100, level 4
// - implemented field bits fully readable and writable
// - register 0: timer1, compare1, capture1, pin0
// - register 1: timer3, timer2, compare2, capture2
// - register 2: conversion, serial tx, rx, sync serial
// - register 3: pin change, twowire collision/transfer, nvm
// - request forwarded only when enable bit set
module ipb_priority_bank #(
  parameter NSRC = 16
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NSRC-1:0] src_flag,
  output reg [3*NSRC-1:0] src_level,
  output reg [NSRC-1:0] src_request
);

  // ===========================================================================
  // storage
  reg [15:0] prio_q [0:3];
  reg [15:0] enable_q;
  reg [7:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  integer i;

  // merge a write into a priority word, dropping the unimplemented bits
  function [15:0] merge_prio;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [15:0] m;
    begin
      m = old;
      if (strb[0]) m[7:0] = data[7:0];
      if (strb[1]) m[15:8] = data[15:8];
      merge_prio = m & `IPB_PRIO_IMPL_MASK;
    end
  endfunction

  function [15:0] merge_plain;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge_plain = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    end
  endfunction

  // ===========================================================================
  // write channel: address and data taken in either order, response after both
  wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire aw_have = aw_held_q | (s_axi_awvalid & s_axi_awready);
  wire w_have = w_held_q | (s_axi_wvalid & s_axi_wready);
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire wr_hit = (wr_addr[7:2] <= `IPB_OFF_ENABLE >> 2) && (wr_addr[1:0] == 2'h0);
  wire [1:0] wr_idx = wr_addr[3:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1)
        prio_q[i] <= `IPB_PRIO_RESET;
      enable_q <= `IPB_ENABLE_RESET;
      awaddr_q <= 8'h00;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPB_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `IPB_RESP_OKAY : `IPB_RESP_SLVERR;
        // stored now, visible from the next edge
        if (wr_hit && wr_addr[4] == 1'b0)
          prio_q[wr_idx] <= merge_prio(prio_q[wr_idx], wr_data, wr_strb);
        else if (wr_hit)
          enable_q <= merge_plain(enable_q, wr_data, wr_strb);
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ===========================================================================
  // per-source gating
  wire [NSRC-1:0] req_w;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : gen_src
      // source g sits in register g/4, field g%4 (0 at bits 2-0)
      ipb_source_gate u_gate (
        .level(prio_q[g / 4][(g % 4) * 4 +: `IPB_FLD_W]),
        .flag(src_flag[g]),
        .enable(enable_q[g]),
        .requesting(req_w[g]),
        .eff_level()
      );
    end
  endgenerate

  // levels go to the arbiter continuously, one edge after a write
  always @(posedge aclk) begin
    if (!aresetn) begin
      src_level <= {NSRC{3'h4}};
      src_request <= {NSRC{1'b0}};
    end else begin
      for (i = 0; i < NSRC; i = i + 1)
        src_level[3*i +: 3] <= prio_q[i / 4][(i % 4) * 4 +: 3];
      src_request <= req_w;
    end
  end

  // ===========================================================================
  // read channel: one read at a time, answered one cycle after arvalid is taken
  reg [31:0] rd_word;
  reg rd_ok;
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[1:0] != 2'h0)
      rd_ok = 1'b0;
    else case (s_axi_araddr)
      `IPB_OFF_PRIO0: rd_word = {16'h0000, prio_q[0] & `IPB_PRIO_IMPL_MASK};
      `IPB_OFF_PRIO1: rd_word = {16'h0000, prio_q[1] & `IPB_PRIO_IMPL_MASK};
      `IPB_OFF_PRIO2: rd_word = {16'h0000, prio_q[2] & `IPB_PRIO_IMPL_MASK};
      `IPB_OFF_PRIO3: rd_word = {16'h0000, prio_q[3] & `IPB_PRIO_IMPL_MASK};
      `IPB_OFF_ENABLE: rd_word = {16'h0000, enable_q};
      `IPB_OFF_PENDING: rd_word = {{(32-NSRC){1'b0}}, src_flag};
      `IPB_OFF_REQUEST: rd_word = {{(32-NSRC){1'b0}}, src_request};
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `IPB_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `IPB_RESP_OKAY : `IPB_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ipb_priority_bank

// *** sim/ipb_arb_model.sv ***
// far-side model: arbitration that picks the highest requesting level
// assumes src_level and src_request come straight from the bank
module ipb_arb_model (
  input wire logic [47:0] src_level,
  input wire logic [15:0] src_request,
  output logic [2:0] top_level
);
  // ==========================================
  // arbitration
  always_comb begin
    top_level = 3'h0;
    for (int g = 0; g < 16; g++) begin
      if (src_request[g] && src_level[3*g+:3] > top_level) top_level = src_level[3*g+:3];
    end
  end
endmodule // ipb_arb_model

// *** sim/ipb_bank_chk.sv ***
// assertions on the priority bank ports
// assumes one clock, synchronous active-low reset
`include "ipb_map.vh"
module ipb_bank_chk #(
  parameter NSRC = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NSRC-1:0] src_flag,
  input wire logic [3*NSRC-1:0] src_level,
  input wire logic [NSRC-1:0] src_request
);
  // ==========================================
  // helpers
  logic [7:0] raddr_q;
  logic [NSRC-1:0] nz;
  always @(posedge aclk) if (s_axi_arvalid && s_axi_arready) raddr_q <= s_axi_araddr;
  for (genvar g = 0; g < NSRC; g++) begin : g_nz
    assign nz[g] = |src_level[3*g+:3];
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // properties
  property p_off; (src_request & ~nz) == '0; endproperty
  a_off: assert property (p_off) else $error("request from level zero");
  property p_flag; (src_request & ~$past(src_flag)) == '0; endproperty
  a_flag: assert property (p_flag) else $error("request without flag");
  property p_rst; $rose(aresetn) |-> src_level == {NSRC{3'h4}} && src_request == '0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset levels");
  property p_unimpl; s_axi_rvalid && raddr_q < 8'h10 |-> (s_axi_rdata & 32'hffff8888) == 32'h0; endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("write taken while busy");
  property p_btime; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
  a_btime: assert property (p_btime) else $error("late write answer");
  property p_rtime; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rtime: assert property (p_rtime) else $error("late read answer");
endmodule // ipb_bank_chk
bind ipb_priority_bank ipb_bank_chk #(.NSRC(NSRC)) i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .src_flag, .src_level, .src_request);

// *** sim/tb_irq_priority_config_bank.sv ***
// bench for the priority bank: reset values, field map, gating, bad addresses
// assumes ipb_map.vh on the include path
`include "ipb_map.vh"
module tb_irq_priority_config_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, b;
  logic [15:0] src_flag = 0, src_request, nz;
  logic [47:0] src_level, e;
  logic [2:0] top_level;
  logic [15:0] v [4] = '{16'h7531, 16'h6420, 16'h1357, 16'h0246};
  int failures = 0, cmp_count = 0, cyc = 0;
  ipb_priority_bank i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_flag,
    .src_level, .src_request);
  ipb_arb_model i_arb (.src_level, .src_request, .top_level);
  always #4 aclk = ~aclk;
  // ==========================================
  // bus and check tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] w, input logic [3:0] s);
    bit ta = 0, tw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= w; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awready) begin ta = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin tw = 1; s_axi_wvalid <= 0; end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    b = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] x);
    cmp_count++;
    if (g !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // level outputs land one edge after the write answer
  task automatic settle(); repeat (2) @(posedge aclk); #1; endtask
  task automatic wrap_up();
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    @(posedge aclk); aresetn <= 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(d, 32'h4444);
    end
    rd(`IPB_OFF_ENABLE);
    chk(d, 32'h0);
    chk(src_level, {16{3'h4}});
  endtask
  task automatic t_fields();
    wr(`IPB_OFF_PRIO0, 32'h0, 4'h2);
    rd(`IPB_OFF_PRIO0);
    chk(d, 32'h0044);
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), {16'hffff, v[i] | 16'h8888}, 4'hf);
      chk(b, `IPB_RESP_OKAY);
      rd(8'(4 * i));
      chk({r, d}, {`IPB_RESP_OKAY, 16'h0, v[i]});
      for (int k = 0; k < 4; k++) e[12*i+3*k+:3] = v[i][4*k+:3];
      for (int k = 0; k < 4; k++) nz[4*i+k] = |v[i][4*k+:3];
    end
    settle();
    chk(src_level, e);
  endtask
  task automatic t_gate();
    @(posedge aclk); src_flag <= 16'hffff;
    settle();
    chk(src_request, 16'h0);
    wr(`IPB_OFF_ENABLE, 32'hffff, 4'hf);
    settle();
    chk(src_request, nz);
    chk(top_level, 3'h7);
    @(posedge aclk); src_flag <= 16'h0001;
    settle();
    chk(top_level, 3'h1);
    @(posedge aclk); src_flag <= 16'hff3f;
    wr(`IPB_OFF_ENABLE, 32'h00f0, 4'hf);
    settle();
    chk(src_request, nz & 16'h0030);
    rd(`IPB_OFF_REQUEST);
    chk(d, nz & 16'h0030);
    rd(`IPB_OFF_PENDING);
    chk(d, 32'hff3f);
  endtask
  task automatic t_bad();
    rd(8'h40);
    chk({r, d}, {`IPB_RESP_SLVERR, 32'h0});
    rd(8'h06);
    chk({r, d}, {`IPB_RESP_SLVERR, 32'h0});
    wr(8'h40, 32'hffff, 4'hf);
    chk(b, `IPB_RESP_SLVERR);
    rd(`IPB_OFF_PRIO3);
    chk(d, {16'h0, v[3]});
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    t_reset();
    t_fields();
    t_gate();
    t_bad();
    t_reset();
    wrap_up();
  end
endmodule // tb_irq_priority_config_bank
